// ==== rtl/cmd_pkg.sv ====
package cmd_pkg;

    typedef enum logic [3:0] {
        type_param = 4'h0,
        type_uvar = 4'h1,
        type_mon = 4'h2,
        type_prio = 4'h3,
        type_trig = 4'h4,
        type_seq = 4'h5,
        type_trace = 4'h6,
        type_lut = 4'h7,
        type_float = 4'h8
    } reg_type_t;

    typedef enum logic [3:0] {
        op_none = 4'h0,
        op_add = 4'h1,
        op_sub = 4'h2,
        op_mul = 4'h3,
        op_div = 4'h4,
        op_not = 4'h5,
        op_and = 4'h6,
        op_or = 4'h7,
        op_andn = 4'h8,
        op_orn = 4'h9,
        op_shr = 4'hA,
        op_shl = 4'hB
    } op_t;

    typedef enum logic [1:0] {
        axis_single = 2'h0,
        axis_list = 2'h1,
        axis_mask = 2'h2
    } axis_mode_t;

    typedef enum logic [0:0] {
        st_idle = 1'h0,
        st_resp = 1'h1
    } state_t;

    localparam logic [15:0] IDX_MAX_PARAM = 16'h01FE;
    localparam logic [15:0] IDX_MAX_MON = 16'h00FF;
    localparam logic [15:0] IDX_MAX_PRIO = 16'h0007;
    localparam logic [15:0] IDX_MAX_TRIG = 16'h00BF;
    localparam logic [15:0] IDX_MAX_SEQ = 16'h1FFE;
    localparam logic [15:0] IDX_MAX_TRACE = 16'h03E7;
    localparam logic [15:0] IDX_MAX_LUT = 16'h07CF;
    localparam logic [15:0] IDX_MAX_FLOAT = 16'h00FF;
    localparam logic [3:0] DEPTH_MAX_PARAM = 4'h3;
    localparam logic [3:0] DEPTH_MAX_PRIO = 4'hB;
    localparam logic [3:0] DEPTH_MAX_TRACE = 4'h1;
    localparam logic [3:0] DEPTH_MAX_LUT = 4'h7;
    localparam logic [4:0] AXIS_MAX = 5'h1E;

    localparam logic [15:0] PARAM_WIN = 16'h0008;
    localparam logic [15:0] UVAR_WIN = 16'h0008;
    localparam logic [15:0] ENC_INDEX = 16'h0044;
    localparam logic [15:0] PHASE_INDEX = 16'h005A;
    localparam logic [15:0] SERIAL_INDEX = 16'h0049;
    localparam logic [4:0] ENC_SLOT = 5'h08;
    localparam logic [4:0] PHASE_SLOT = 5'h09;
    localparam logic [4:0] UVAR_BASE = 5'h0A;
    localparam int SLOTS = 18;

    localparam logic [31:0] ENC_DEFAULT = 32'h0000_0000;
    localparam logic [31:0] ENC_MIN = 32'h0000_0000;
    localparam logic [31:0] ENC_MAX = 32'h0000_0007;
    localparam logic [31:0] PHASE_DEFAULT = 32'h0000_0001;
    localparam logic [31:0] PHASE_MIN = 32'h0000_0001;
    localparam logic [31:0] PHASE_MAX = 32'h0000_0007;
    localparam logic [31:0] WORD_MIN = 32'h8000_0000;
    localparam logic [31:0] WORD_MAX = 32'h7FFF_FFFF;

    function automatic logic [15:0] idx_max(reg_type_t t);
        case (t)
            type_param, type_uvar: idx_max = IDX_MAX_PARAM;
            type_mon: idx_max = IDX_MAX_MON;
            type_prio: idx_max = IDX_MAX_PRIO;
            type_trig: idx_max = IDX_MAX_TRIG;
            type_seq: idx_max = IDX_MAX_SEQ;
            type_trace: idx_max = IDX_MAX_TRACE;
            type_lut: idx_max = IDX_MAX_LUT;
            default: idx_max = IDX_MAX_FLOAT;
        endcase
    endfunction

    function automatic logic [3:0] depth_max(reg_type_t t);
        case (t)
            type_param, type_trig: depth_max = DEPTH_MAX_PARAM;
            type_prio: depth_max = DEPTH_MAX_PRIO;
            type_trace: depth_max = DEPTH_MAX_TRACE;
            type_lut: depth_max = DEPTH_MAX_LUT;
            default: depth_max = 4'h0;
        endcase
    endfunction

endpackage

// ==== rtl/reg_range_check.sv ====
`timescale 1ns/1ps
`default_nettype none
module reg_range_check (
    // Register address
    input wire cmd_pkg::reg_type_t typ,
    input wire logic [15:0] index,
    input wire logic [3:0] depth,
    // Access kind
    input wire logic write,
    input wire cmd_pkg::op_t op,
    // Verdict
    output logic ok
);
    logic logic_op;

    always_comb begin
        logic_op = op >= cmd_pkg::op_not;
        ok = index <= cmd_pkg::idx_max(typ);
        if (depth > cmd_pkg::depth_max(typ)) begin
            ok = 1'b0;
        end
        if (write) begin
            if (typ == cmd_pkg::type_mon) begin
                ok = 1'b0;
            end
            // Operators only on parameters and user variables.
            if (op != cmd_pkg::op_none && typ != cmd_pkg::type_param &&
                    typ != cmd_pkg::type_uvar) begin
                ok = 1'b0;
            end
            // Float takes no logic or shift operator.
            if (typ == cmd_pkg::type_float && logic_op) begin
                ok = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/value_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
module value_alu (
    // Operation
    input wire cmd_pkg::op_t op,
    input wire logic signed [31:0] cur,
    input wire logic signed [31:0] opd,
    // Limits of the target
    input wire logic signed [31:0] lo,
    input wire logic signed [31:0] hi,
    // Result
    output logic [31:0] result,
    output logic div_zero
);
    logic signed [63:0] wide;

    // Work in 64 bits so that overflow is clamped instead of wrapped.
    always_comb begin
        div_zero = 1'b0;
        case (op)
            cmd_pkg::op_add: wide = 64'(cur) + 64'(opd);
            cmd_pkg::op_sub: wide = 64'(cur) - 64'(opd);
            cmd_pkg::op_mul: wide = 64'(cur) * 64'(opd);
            // Quotient truncated to its integer part.
            cmd_pkg::op_div: begin
                if (opd == 32'sh0000_0000) begin
                    div_zero = 1'b1;
                    wide = 64'(cur);
                end else begin
                    wide = 64'(cur) / 64'(opd);
                end
            end
            cmd_pkg::op_not: wide = 64'(~opd);
            cmd_pkg::op_and: wide = 64'(cur & opd);
            cmd_pkg::op_or: wide = 64'(cur | opd);
            cmd_pkg::op_andn: wide = 64'(cur & ~opd);
            cmd_pkg::op_orn: wide = 64'(cur | ~opd);
            cmd_pkg::op_shr: wide = 64'(cur >>> opd[4:0]);
            cmd_pkg::op_shl: wide = 64'(cur) <<< opd[4:0];
            default: wide = 64'(opd);
        endcase
        if (wide > 64'(hi)) begin
            result = hi;
        end else if (wide < 64'(lo)) begin
            result = lo;
        end else begin
            result = wide[31:0];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/register_access_command_parser.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Compound operators only on parameter and user-variable registers.
// - Shifts are arithmetic; float registers refuse logic and shift operators.
// - Values beyond a register's limits store the nearest limit, any depth.
// - Depth 0 takes each register's default; depths 1 to 3 reset to zero.
// - Operand is an immediate or another register at any depth.
// - Index ranges per register type are checked on every access.
// - Depth ranges per register type are checked on every access.
// - Missing depth means depth 0 for reads and writes.
// - Parameter registers hold four independent values, one per depth.
// - Depth selects priority level or trigger line for those types.
// - Axis field is one axis up to 30, a list or a mask.
// - A paired read is served only when both registers share an axis.
// - Each command is answered; an aliased register answers by alias.
// - Monitor registers refuse writes; user variables, monitors, sequences and floats have depth 0 only.
// - Division stores the integer part of the quotient.
// - Equals sign is mandatory on writes; an operator combines target and operand.
// - Bit-field registers enable one function per bit; zero disables all.
// - Direction bits invert analog count, digital count and force reference.
// - Each phasing mode value selects exactly one function.
module register_access_command_parser #(
    // Arbitrary value, not tied to any unit.
    parameter logic [31:0] serial_number = 32'h0000_1234
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Own axis address
    input wire logic [4:0] own_axis,
    // Parsed command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic cmd_equals,
    input wire cmd_pkg::op_t cmd_op,
    input wire cmd_pkg::reg_type_t cmd_type,
    input wire logic [15:0] cmd_index,
    input wire logic cmd_depth_given,
    input wire logic [3:0] cmd_depth,
    input wire cmd_pkg::axis_mode_t cmd_axis_mode,
    input wire logic [4:0] cmd_axis,
    input wire logic [31:0] cmd_axis_mask,
    input wire logic [31:0] cmd_imm,
    // Second register: write operand or second read
    input wire logic cmd_src_used,
    input wire cmd_pkg::reg_type_t src_type,
    input wire logic [15:0] src_index,
    input wire logic src_depth_given,
    input wire logic [3:0] src_depth,
    input wire logic [4:0] src_axis,
    // Response
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic rsp_error,
    output logic rsp_alias,
    output logic rsp_pair,
    output logic [31:0] rsp_value,
    output logic [31:0] rsp_value2,
    // Functions steered by registers
    output logic analog_enc_invert,
    output logic ttl_enc_invert,
    output logic force_ref_invert,
    output logic [6:0] phasing_mode_onehot
);
    cmd_pkg::state_t state;
    cmd_pkg::state_t next_state;
    // Four depth words per slot, all kept at once.
    logic [cmd_pkg::SLOTS-1:0][3:0][31:0] store;
    logic [cmd_pkg::SLOTS-1:0][3:0][31:0] next_store;
    logic next_ready;
    logic next_rsp_valid;
    logic next_error;
    logic next_alias;
    logic next_pair;
    logic [31:0] next_value;
    logic [31:0] next_value2;
    logic [6:0] next_onehot;
    logic [3:0] d_tgt;
    logic [3:0] d_src;
    logic [1:0] d_lo;
    logic [5:0] tgt_slot;
    logic [4:0] tslot;
    logic tgt_ok;
    logic src_ok;
    logic sel;
    logic axis_bad;
    logic pair_bad;
    logic src_far;
    logic bad;
    logic go;
    logic take;
    logic [31:0] cur;
    logic [31:0] opd;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] alu_result;
    logic div_zero;

    // Only a window of parameters and user variables, plus ENC_INDEX and PHASE_INDEX, is backed by flops;
    // other valid indices drop writes and read zero, the serial number monitor excepted, which keeps area small.
    function automatic logic [5:0] slot_of(cmd_pkg::reg_type_t t,
                                           logic [15:0] i);
        slot_of = 6'h00;
        if (t == cmd_pkg::type_param && i < cmd_pkg::PARAM_WIN) begin
            slot_of = {1'b1, i[4:0]};
        end else if (t == cmd_pkg::type_param && i == cmd_pkg::ENC_INDEX) begin
            slot_of = {1'b1, cmd_pkg::ENC_SLOT};
        end else if (t == cmd_pkg::type_param &&
                     i == cmd_pkg::PHASE_INDEX) begin
            slot_of = {1'b1, cmd_pkg::PHASE_SLOT};
        end else if (t == cmd_pkg::type_uvar && i < cmd_pkg::UVAR_WIN) begin
            slot_of = {1'b1, 5'(cmd_pkg::UVAR_BASE + i[4:0])};
        end
    endfunction

    function automatic logic [31:0] rd(cmd_pkg::reg_type_t t,
                                       logic [15:0] i, logic [3:0] d);
        logic [5:0] s;
        s = slot_of(t, i);
        rd = 32'h0000_0000;
        // Depth picks the word, whatever the type calls it.
        if (s[5]) begin
            rd = store[s[4:0]][d[1:0]];
        end else if (t == cmd_pkg::type_mon && i == cmd_pkg::SERIAL_INDEX) begin
            rd = serial_number;
        end
    endfunction

    function automatic logic [3:0] eff_depth(logic given, logic [3:0] d);
        // No depth field means depth 0.
        eff_depth = given ? d : 4'h0;
    endfunction

    assign d_tgt = eff_depth(cmd_depth_given, cmd_depth);
    assign d_src = eff_depth(src_depth_given, src_depth);
    assign d_lo = d_tgt[1:0];
    assign tgt_slot = slot_of(cmd_type, cmd_index);
    assign tslot = tgt_slot[4:0];
    assign take = cmd_valid && cmd_ready;

    reg_range_check tgt_check (
        .typ(cmd_type),
        .index(cmd_index),
        .depth(d_tgt),
        .write(!cmd_read),
        .op(cmd_op),
        .ok(tgt_ok)
    );

    reg_range_check src_check (
        .typ(src_type),
        .index(src_index),
        .depth(d_src),
        .write(1'b0),
        .op(cmd_pkg::op_none),
        .ok(src_ok)
    );

    // One axis, a list or a mask selects this axis.
    assign axis_bad = cmd_axis_mode == cmd_pkg::axis_single &&
                      cmd_axis > cmd_pkg::AXIS_MAX;
    assign sel = cmd_axis_mode == cmd_pkg::axis_single ?
                 cmd_axis == own_axis : cmd_axis_mask[own_axis];
    // Paired reads need one and the same axis.
    assign pair_bad = cmd_read && cmd_src_used &&
                      (cmd_axis_mode != cmd_pkg::axis_single ||
                       src_axis != cmd_axis);
    // Register operands are fetched from this axis only.
    assign src_far = !cmd_read && cmd_src_used && src_axis != own_axis;
    always_comb begin
        cur = rd(cmd_type, cmd_index, d_tgt);
        opd = cmd_src_used ? rd(src_type, src_index, d_src) : cmd_imm;
    end
    assign lo = tslot == cmd_pkg::ENC_SLOT && tgt_slot[5] ? cmd_pkg::ENC_MIN :
                tslot == cmd_pkg::PHASE_SLOT && tgt_slot[5] ?
                cmd_pkg::PHASE_MIN : cmd_pkg::WORD_MIN;
    assign hi = tslot == cmd_pkg::ENC_SLOT && tgt_slot[5] ? cmd_pkg::ENC_MAX :
                tslot == cmd_pkg::PHASE_SLOT && tgt_slot[5] ?
                cmd_pkg::PHASE_MAX : cmd_pkg::WORD_MAX;

    value_alu alu (
        .op(cmd_op),
        .cur(cur),
        .opd(opd),
        .lo(lo),
        .hi(hi),
        .result(alu_result),
        .div_zero(div_zero)
    );

    // Any fault blocks the store update.
    assign bad = !tgt_ok || (cmd_src_used && !src_ok) || axis_bad ||
                 pair_bad || (!cmd_read && (!cmd_equals || src_far ||
                 div_zero));
    assign go = !cmd_read && !bad && sel && tgt_slot[5];

    always_comb begin
        next_state = state;
        next_store = store;
        next_ready = cmd_ready;
        next_rsp_valid = rsp_valid;
        next_error = rsp_error;
        next_alias = rsp_alias;
        next_pair = rsp_pair;
        next_value = rsp_value;
        next_value2 = rsp_value2;
        case (state)
            cmd_pkg::st_idle: begin
                if (cmd_valid) begin
                    next_state = cmd_pkg::st_resp;
                    next_ready = 1'b0;
                    next_rsp_valid = 1'b1;
                    next_error = bad;
                    // Aliased register answers under its alias.
                    next_alias = cmd_type == cmd_pkg::type_mon &&
                                 cmd_index == cmd_pkg::SERIAL_INDEX;
                    next_pair = cmd_read && cmd_src_used;
                    next_value = cmd_read ? cur : alu_result;
                    next_value2 = opd;
                    // Combined value is stored in the target.
                    if (go) begin
                        next_store[tslot][d_lo] = alu_result;
                    end
                end
            end
            cmd_pkg::st_resp: begin
                if (rsp_ready) begin
                    next_state = cmd_pkg::st_idle;
                    next_ready = 1'b1;
                    next_rsp_valid = 1'b0;
                end
            end
            default: begin
                next_state = cmd_pkg::st_idle;
                next_ready = 1'b1;
                next_rsp_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= cmd_pkg::st_idle;
            // Defaults at depth 0, zero at deeper depths.
            store <= '0;
            store[cmd_pkg::ENC_SLOT][0] <= cmd_pkg::ENC_DEFAULT;
            store[cmd_pkg::PHASE_SLOT][0] <= cmd_pkg::PHASE_DEFAULT;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_alias <= 1'b0;
            rsp_pair <= 1'b0;
            rsp_value <= 32'h0000_0000;
            rsp_value2 <= 32'h0000_0000;
        end else begin
            state <= next_state;
            store <= next_store;
            cmd_ready <= next_ready;
            rsp_valid <= next_rsp_valid;
            rsp_error <= next_error;
            rsp_alias <= next_alias;
            rsp_pair <= next_pair;
            rsp_value <= next_value;
            rsp_value2 <= next_value2;
        end
    end

    // One bit per function; zero leaves them all off.
    // Direction bits of the depth 0 word.
    assign analog_enc_invert = store[cmd_pkg::ENC_SLOT][0][0];
    assign ttl_enc_invert = store[cmd_pkg::ENC_SLOT][0][1];
    assign force_ref_invert = store[cmd_pkg::ENC_SLOT][0][2];

    // Each mode value selects one function.
    always_comb begin
        next_onehot = 7'h00;
        for (int m = 1; m <= 7; m++) begin
            if (store[cmd_pkg::PHASE_SLOT][0] == 32'(m)) begin
                next_onehot[m-1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phasing_mode_onehot <= 7'h01;
        end else begin
            phasing_mode_onehot <= next_onehot;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_monitor_write:
    assert property (take && !cmd_read && cmd_type == cmd_pkg::type_mon
                     |=> rsp_valid && rsp_error)
        else $error("write to monitor accepted");

    a_reject_keeps:
    assert property (take ##1 rsp_error |-> store == $past(store))
        else $error("rejected command changed a register");

    a_operator_types:
    assert property (take && !cmd_read && cmd_op != cmd_pkg::op_none &&
                     cmd_type != cmd_pkg::type_param &&
                     cmd_type != cmd_pkg::type_uvar |=> rsp_error)
        else $error("operator accepted on wrong type");

    a_float_logic:
    assert property (take && !cmd_read && cmd_type == cmd_pkg::type_float &&
                     cmd_op >= cmd_pkg::op_not |=> rsp_error)
        else $error("logic operator accepted on float");

    a_equals_needed:
    assert property (take && !cmd_read && !cmd_equals |=> rsp_error)
        else $error("write without equals accepted");

    a_pair_axis:
    assert property (take && cmd_read && cmd_src_used && src_axis != cmd_axis
                     |=> rsp_error)
        else $error("paired read across axes served");

    a_depth_range:
    assert property (take && cmd_type == cmd_pkg::type_prio &&
                     cmd_depth_given && cmd_depth > 4'hB |=> rsp_error)
        else $error("priority depth above 11 accepted");

    a_axis_range:
    assert property (take && cmd_axis_mode == cmd_pkg::axis_single &&
                     cmd_axis > 5'h1E |=> rsp_error)
        else $error("axis above 30 accepted");

    a_phase_clamp:
    assert property (take && go && tslot == cmd_pkg::PHASE_SLOT |=>
                     store[cmd_pkg::PHASE_SLOT][$past(d_lo)] >= 32'h1 &&
                     store[cmd_pkg::PHASE_SLOT][$past(d_lo)] <= 32'h7)
        else $error("phasing value stored outside limits");

    a_default_depth:
    assert property (take && cmd_read && !cmd_depth_given && tgt_slot[5]
                     |=> rsp_value == store[$past(tslot)][0])
        else $error("read without depth not from depth 0");

    a_enc_bits:
    assert property (take && go && tslot == cmd_pkg::ENC_SLOT && d_lo == 2'h0
                     && alu_result == 32'h0000_0005 |=> ##1 analog_enc_invert
                     && !ttl_enc_invert && force_ref_invert)
        else $error("direction bits not applied");

    a_mode_onehot:
    assert property ($onehot(phasing_mode_onehot))
        else $error("phasing mode not one-hot");

    c_pair_read: cover property (take && cmd_read && cmd_src_used ##1
                                 !rsp_error);
    c_compound_write: cover property (take && go && cmd_op != cmd_pkg::op_none);
    c_alias_read: cover property (take ##1 rsp_alias);
endmodule
`default_nettype wire

// ==== tb/host_link.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_link (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Response side
    input wire logic rsp_valid,
    input wire logic slow,
    output logic rsp_ready,
    output logic [15:0] taken
);
    // Stalling every other cycle shows a response standing until taken.
    // Answers accepted.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_ready <= 1'b0;
            taken <= 16'h0000;
        end else begin
            rsp_ready <= slow ? ~rsp_ready : 1'b1;
            if (rsp_valid && rsp_ready) taken <= taken + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== tb/register_access_command_parser_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module register_access_command_parser_tb;
    logic clk, rst_n, cmd_valid, cmd_ready, cmd_read, cmd_equals, s_use;
    logic cmd_depth_given, cmd_src_used, src_depth_given, rsp_valid, e;
    logic rsp_ready, rsp_error, rsp_alias, rsp_pair, slow, al, pr;
    logic analog_enc_invert, ttl_enc_invert, force_ref_invert;
    logic [4:0] own_axis, cmd_axis, src_axis, ax;
    logic [3:0] cmd_depth, src_depth, s_dp;
    logic [15:0] cmd_index, src_index, taken, s_ix;
    logic [31:0] cmd_axis_mask, cmd_imm, rsp_value, rsp_value2, v, v2, mk;
    logic [6:0] phasing_mode_onehot;
    cmd_pkg::op_t cmd_op;
    cmd_pkg::reg_type_t cmd_type, src_type, s_ty;
    cmd_pkg::axis_mode_t cmd_axis_mode;
    int failures, comparisons, sent;
    assign own_axis = 5'h02;
    assign src_depth_given = 1'b1;
    register_access_command_parser register_access_command_parser_inst (
        .clk, .rst_n, .own_axis, .cmd_valid, .cmd_ready, .cmd_read,
        .cmd_equals, .cmd_op, .cmd_type, .cmd_index, .cmd_depth_given,
        .cmd_depth, .cmd_axis_mode, .cmd_axis, .cmd_axis_mask, .cmd_imm,
        .cmd_src_used, .src_type, .src_index, .src_depth_given, .src_depth,
        .src_axis, .rsp_valid, .rsp_ready, .rsp_error, .rsp_alias,
        .rsp_pair, .rsp_value, .rsp_value2, .analog_enc_invert,
        .ttl_enc_invert, .force_ref_invert, .phasing_mode_onehot
    );
    host_link host_link_inst (
        .clk, .rst_n, .rsp_valid, .slow, .rsp_ready, .taken
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task close_out;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task go(input logic rd, eq, input cmd_pkg::op_t op,
            input cmd_pkg::reg_type_t ty, input logic [15:0] ix,
            input logic dg, input logic [3:0] dp, input logic [31:0] m);
        int n;
        n = 0;
        @(posedge clk);
        {cmd_read, cmd_equals, cmd_depth_given} <= {rd, eq, dg};
        {cmd_index, cmd_depth, cmd_imm, src_index} <= {ix, dp, m, s_ix};
        {src_depth, cmd_axis, src_axis, cmd_src_used} <= {s_dp, ax, ax, s_use};
        cmd_axis_mode <= |mk ? cmd_pkg::axis_mask : cmd_pkg::axis_single;
        cmd_axis_mask <= mk;
        cmd_op <= op;
        cmd_type <= ty;
        src_type <= s_ty;
        cmd_valid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        @(posedge clk);
        cmd_valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 50);
        {e, al, pr, v, v2} = {rsp_error, rsp_alias, rsp_pair, rsp_value,
                              rsp_value2};
        sent++;
        while (rsp_valid === 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) begin
            failures++;
            close_out;
        end
    endtask
    task wp(input logic [15:0] i, input logic [3:0] d,
            input cmd_pkg::op_t o, input logic [31:0] m);
        go(1'b0, 1'b1, o, cmd_pkg::type_param, i, 1'b1, d, m);
    endtask
    task t_store;
        go(1'b1, 1'b0, cmd_pkg::op_none, cmd_pkg::type_param,
           cmd_pkg::PHASE_INDEX, 1'b0, 4'h0, 32'h0000_0000);
        chk("phase", v, 32'h0000_0001);
        chk("mode", phasing_mode_onehot, 32'h0000_0001);
        wp(cmd_pkg::ENC_INDEX, 4'h1, cmd_pkg::op_none, 32'h0000_0002);
        go(1'b1, 1'b0, cmd_pkg::op_none, cmd_pkg::type_param,
           cmd_pkg::ENC_INDEX, 1'b0, 4'h0, 32'h0000_0000);
        chk("enc", v, 32'h0000_0000);
        wp(16'h0003, 4'h2, cmd_pkg::op_none, 32'h0000_0017);
        go(1'b0, 1'b1, cmd_pkg::op_none, cmd_pkg::type_param, 16'h0003,
           1'b0, 4'h0, 32'h0000_000F);
        go(1'b1, 1'b0, cmd_pkg::op_none, cmd_pkg::type_prio, 16'h0007,
           1'b1, 4'hB, 32'h0000_0000);
        chk("prio", e, 32'h0000_0000);
    endtask
    task t_ops;
        logic signed [31:0] c, o, x;
        c = 32'hFFFF_FFF4;
        o = 32'h0000_0005;
        for (int k = 1; k < 12; k++) begin
            case (k)
                1: x = c + o;
                2: x = c - o;
                3: x = c * o;
                4: x = c / o;
                5: x = ~o;
                6: x = c & o;
                7: x = c | o;
                8: x = c & ~o;
                9: x = c | ~o;
                10: x = c >>> o;
                default: x = c << o;
            endcase
            wp(16'h0001, 4'h0, cmd_pkg::op_none, c);
            wp(16'h0001, 4'h0, cmd_pkg::op_t'(k), o);
            chk("op", v, x);
        end
    endtask
    task t_limits;
        wp(cmd_pkg::ENC_INDEX, 4'h0, cmd_pkg::op_none, 32'h0000_0005);
        chk("bits", {force_ref_invert, ttl_enc_invert, analog_enc_invert},
            32'h0000_0005);
        wp(cmd_pkg::ENC_INDEX, 4'h0, cmd_pkg::op_add, 32'h0000_0009);
        chk("hi", v, 32'h0000_0007);
        wp(cmd_pkg::PHASE_INDEX, 4'h3, cmd_pkg::op_none, 32'h0000_0000);
        chk("lo", v, 32'h0000_0001);
        for (int m = 1; m < 8; m++) begin
            wp(cmd_pkg::PHASE_INDEX, 4'h0, cmd_pkg::op_none, m);
            chk("mode", phasing_mode_onehot, 1 << (m - 1));
        end
    endtask
    task t_refuse;
        go(1'b0, 1'b1, cmd_pkg::op_none, cmd_pkg::type_mon, 16'h0004, 1'b0,
           4'h0, 32'h0000_0001);
        chk("mon", e, 32'h0000_0001);
        go(1'b0, 1'b1, cmd_pkg::op_add, cmd_pkg::type_trig, 16'h0001, 1'b0,
           4'h0, 32'h0000_0001);
        chk("trig", e, 32'h0000_0001);
        go(1'b0, 1'b1, cmd_pkg::op_and, cmd_pkg::type_float, 16'h0001, 1'b0,
           4'h0, 32'h0000_0001);
        chk("float", e, 32'h0000_0001);
        wp(16'h01FF, 4'h0, cmd_pkg::op_none, 32'h0000_0001);
        chk("index", e, 32'h0000_0001);
        wp(16'h0003, 4'h4, cmd_pkg::op_none, 32'h0000_0001);
        chk("depth", e, 32'h0000_0001);
        ax = 5'h1F;
        wp(16'h0003, 4'h0, cmd_pkg::op_none, 32'h0000_0001);
        chk("axis", e, 32'h0000_0001);
        ax = 5'h02;
        go(1'b0, 1'b0, cmd_pkg::op_none, cmd_pkg::type_param, 16'h0003,
           1'b0, 4'h0, 32'h0000_0001);
        chk("sign", e, 32'h0000_0001);
        mk = 32'h0000_0008;
        wp(16'h0003, 4'h0, cmd_pkg::op_none, 32'h0000_0001);
        mk = 32'h0000_0004;
        wp(16'h0003, 4'h0, cmd_pkg::op_add, 32'h0000_0001);
        mk = 32'h0000_0000;
    endtask
    task t_pair;
        slow = 1'b1;
        {s_use, s_ix, s_dp} = {1'b1, 16'h0003, 4'h2};
        wp(16'h0002, 4'h1, cmd_pkg::op_none, 32'h0000_0000);
        chk("src", v, 32'h0000_0017);
        s_dp = 4'h0;
        go(1'b1, 1'b0, cmd_pkg::op_none, cmd_pkg::type_param, 16'h0002,
           1'b1, 4'h1, 32'h0000_0000);
        chk("pair", {pr, v[7:0], v2[7:0]}, 32'h0001_1710);
        s_use = 1'b0;
        go(1'b1, 1'b0, cmd_pkg::op_none, cmd_pkg::type_mon,
           cmd_pkg::SERIAL_INDEX, 1'b0, 4'h0, 32'h0000_0000);
        chk("alias", {al, v[15:0]}, 32'h0001_1234);
        chk("taken", taken, sent);
    endtask
    initial begin
        {rst_n, cmd_valid, cmd_read, cmd_equals, slow, s_use} = 6'h00;
        {cmd_depth_given, cmd_src_used, cmd_axis, src_axis} = 12'h000;
        {cmd_index, src_index, s_ix, cmd_depth, src_depth, s_dp} = '0;
        {cmd_imm, ax, mk} = {32'h0000_0000, 5'h02, 32'h0000_0000};
        cmd_op = cmd_pkg::op_none;
        cmd_type = cmd_pkg::type_param;
        src_type = cmd_pkg::type_param;
        s_ty = cmd_pkg::type_param;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_store;
        t_ops;
        t_limits;
        t_refuse;
        t_pair;
        close_out;
    end
endmodule
`default_nettype wire
